// file: core/halt_idle_wakeup_control.sv
// Purpose: Full-stop and low-activity mode control with port L wakeup
// Assumes: sys_clk is the oscillator clock; inputs synchronous to it
// Notes:   Single clock domain; all outputs registered
`timescale 1ns/1ps
module halt_idle_wakeup_control
	import halt_idle_pkg::*;
#(
	parameter bit HALT_ENABLE = 1'b1,
	parameter bit XTAL_OSC    = 1'b1
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        clkEn,
	// APB
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Wake sources
	input  wire logic [7:0]  portL,
	input  wire logic        clockOutPin,
	input  wire logic        resetPinN,
	// Chip-side controls
	output logic             instrClkEn,
	output logic             oscEnable,
	output logic             cpuClkEn,
	output logic             idleTimerIrq,
	output logic             portLIrq
);
	import halt_idle_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		// Mode and software registers
		pmode_t      mode;
		logic [7:0]  wakeEn;
		logic [7:0]  wakeEdge;
		logic [7:0]  wakePend;
		logic        clock_delay_select;
		logic        idle_timer_irq_enable;
		logic        idle_timer_pending;
		logic        port_l_irq_enable;
		logic        global_irq_enable;
		logic        refused;
		// Counters
		logic [3:0]  divCnt;
		logic [15:0] idleTimer;
		logic [8:0]  startCnt;
		// Pin history for edge detection
		logic [7:0]  portLPrev;
		logic        ckoPrev;
		// Bus answer
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		// Registered chip-side outputs
		logic        tick;
		logic        oscEn;
		logic        cpuEn;
		logic        t0Irq;
		logic        lIrq;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic isMapped(input logic [11:0] a);
		return a == OFS_WAKE_EN || a == OFS_WAKE_EDGE || a == OFS_WAKE_PEND ||
			a == OFS_MODE_CTRL || a == OFS_IRQ_CTRL || a == OFS_STATUS ||
			a == OFS_IDLE_TIMER;
	endfunction

	// ------------------------------------------------------------
	// Read word packing
	// ------------------------------------------------------------
	// Mode control reads the live mode, so a refused or ignored
	// halt request shows as zero in the halt position
	function automatic logic [31:0] modeWord(input state_t s);
		logic [31:0] w;
		w            = '0;
		w[MC_HALT]   = s.mode == S_HALT;
		w[MC_IDLE]   = s.mode == S_IDLE;
		w[MC_CLOCK_DELAY_SELECT] = s.clock_delay_select;
		return w;
	endfunction

	function automatic logic [31:0] irqWord(input state_t s);
		logic [31:0] w;
		w           = '0;
		w[IC_IDLE_TIMER_IRQ_ENABLE]  = s.idle_timer_irq_enable;
		w[IC_IDLE_TIMER_PENDING] = s.idle_timer_pending;
		w[IC_PORT_L_IRQ_ENABLE]  = s.port_l_irq_enable;
		w[IC_GIE]   = s.global_irq_enable;
		return w;
	endfunction

	function automatic logic [31:0] statusWord(input state_t s);
		logic [31:0] w;
		w            = '0;
		w[ST_RUN]    = s.mode == S_RUN;
		w[ST_HALT]   = s.mode == S_HALT;
		w[ST_IDLE]   = s.mode == S_IDLE;
		w[ST_START]  = s.mode == S_START;
		w[ST_REFUSE] = s.refused;
		return w;
	endfunction

	// Unmapped offsets read as zero alongside the error response
	function automatic logic [31:0] readWord(input logic [11:0] a, input state_t s);
		logic [31:0] w;
		w = SLVERR_DATA;
		case (a)
			OFS_WAKE_EN:    w = {24'h000000, s.wakeEn};
			OFS_WAKE_EDGE:  w = {24'h000000, s.wakeEdge};
			OFS_WAKE_PEND:  w = {24'h000000, s.wakePend};
			OFS_MODE_CTRL:  w = modeWord(s);
			OFS_IRQ_CTRL:   w = irqWord(s);
			OFS_STATUS:     w = statusWord(s);
			OFS_IDLE_TIMER: w = {16'h0000, s.idleTimer};
			default:        w = SLVERR_DATA;
		endcase
		return w;
	endfunction

	// Any pin both enabled and pending: wakes, refuses halt, interrupts
	function automatic logic anyArmed(input logic [7:0] en, input logic [7:0] pend);
		return |(en & pend);
	endfunction

	logic [7:0] edgeHit;
	logic       apbAcc;
	logic       apbWr;
	logic [7:0] riseHit;
	logic [7:0] fallHit;

	assign apbAcc = psel && penable && !st_r.pready;
	assign apbWr  = apbAcc && pwrite && isMapped(paddr);

	// Per-pin edge detector: edge select one picks a falling edge
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : gEdge
			assign riseHit[gi] = !st_r.portLPrev[gi] && portL[gi];
			assign fallHit[gi] = st_r.portLPrev[gi] && !portL[gi];
			assign edgeHit[gi] = st_r.wakeEdge[gi] ? fallHit[gi] : riseHit[gi];
		end
	endgenerate

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic        wakePin;
		logic        ckoRise;
		logic        bitToggle;
		logic        haltReq;
		logic        idleReq;
		logic [15:0] timerNext;
		wakePin   = 1'b0;
		ckoRise   = 1'b0;
		bitToggle = 1'b0;
		haltReq   = 1'b0;
		idleReq   = 1'b0;
		timerNext = '0;
		st_nxt    = st_r;

		st_nxt.portLPrev = portL;
		st_nxt.ckoPrev   = clockOutPin;
		ckoRise          = !st_r.ckoPrev && clockOutPin;

		// Oscillator divided by ten; frozen in halt
		st_nxt.tick = 1'b0;
		if (st_r.mode != S_HALT) begin
			if (st_r.divCnt == OSC_DIV - 4'h1) begin
				st_nxt.divCnt = 4'h0;
				st_nxt.tick   = 1'b1;
			end else begin
				st_nxt.divCnt = st_r.divCnt + 4'h1;
			end
		end

		// Idle timer runs in run and idle modes only
		timerNext = st_r.idleTimer + 16'h0001;
		if (st_r.tick && (st_r.mode == S_RUN || st_r.mode == S_IDLE)) begin
			st_nxt.idleTimer = timerNext;
			bitToggle = timerNext[IDLE_BIT] != st_r.idleTimer[IDLE_BIT];
		end

		// Pending bits: hardware set wins over a software clear
		st_nxt.wakePend = st_r.wakePend;
		st_nxt.idle_timer_pending    = st_r.idle_timer_pending;

		// ------------------------------------------------------------
		// APB register access, answered in the cycle after the access is seen
		// ------------------------------------------------------------
		st_nxt.pready  = apbAcc;
		st_nxt.pslverr = apbAcc && !isMapped(paddr);
		st_nxt.prdata  = st_r.prdata;
		if (apbAcc && !pwrite)
			st_nxt.prdata = readWord(paddr, st_r);
		if (apbWr) begin
			case (paddr)
				OFS_WAKE_EN:   st_nxt.wakeEn   = pwdata[7:0];
				OFS_WAKE_EDGE: st_nxt.wakeEdge = pwdata[7:0];
				OFS_WAKE_PEND: st_nxt.wakePend = pwdata[7:0];
				OFS_MODE_CTRL: begin
					st_nxt.clock_delay_select = pwdata[MC_CLOCK_DELAY_SELECT];
					haltReq = pwdata[MC_HALT] && HALT_ENABLE;
					idleReq = pwdata[MC_IDLE];
				end
				OFS_IRQ_CTRL: begin
					st_nxt.idle_timer_irq_enable  = pwdata[IC_IDLE_TIMER_IRQ_ENABLE];
					st_nxt.idle_timer_pending = pwdata[IC_IDLE_TIMER_PENDING];
					st_nxt.port_l_irq_enable  = pwdata[IC_PORT_L_IRQ_ENABLE];
					st_nxt.global_irq_enable   = pwdata[IC_GIE];
				end
				default: ;
			endcase
		end
		// Hardware sets after the write so a same-cycle clear loses
		st_nxt.wakePend = st_nxt.wakePend | edgeHit;
		if (bitToggle)
			st_nxt.idle_timer_pending = 1'b1;

		wakePin = anyArmed(st_r.wakeEn, st_r.wakePend);

		// ------------------------------------------------------------
		// Mode sequencing
		// ------------------------------------------------------------
		case (st_r.mode)
			S_RUN: begin
				// A refusal stays visible in status until a halt is accepted
				if (haltReq) begin
					if (anyArmed(st_nxt.wakeEn, st_nxt.wakePend)) begin
						st_nxt.refused = 1'b1;
					end else begin
						st_nxt.refused = 1'b0;
						st_nxt.mode    = S_HALT;
					end
				end else if (idleReq) begin
					st_nxt.mode = S_IDLE;
				end
			end
			S_HALT: begin
				if (wakePin || (ckoRise && !XTAL_OSC)) begin
					// With a crystal or delay select only the oscillator restarts and the chip waits for timeout; otherwise straight to run
					if (XTAL_OSC || st_r.clock_delay_select) begin
						st_nxt.mode     = S_START;
						st_nxt.startCnt = STARTUP_LOAD;
					end else begin
						st_nxt.mode = S_RUN;
					end
				end
			end
			S_IDLE: begin
				// Resume at the next instruction; interrupt taken if enabled
				if (wakePin || bitToggle)
					st_nxt.mode = S_RUN;
			end
			S_START: begin
				// One count per instruction tick, released on the last one
				if (st_r.tick) begin
					if (st_r.startCnt == 9'h001)
						st_nxt.mode = S_RUN;
					st_nxt.startCnt = st_r.startCnt - 9'h001;
				end
			end
			default: st_nxt.mode = S_RUN;
		endcase

		// Registered chip-side outputs
		st_nxt.oscEn = st_nxt.mode != S_HALT;
		st_nxt.cpuEn = st_nxt.mode == S_RUN;
		st_nxt.t0Irq = st_nxt.idle_timer_pending && st_nxt.idle_timer_irq_enable && st_nxt.global_irq_enable;
		st_nxt.lIrq  = anyArmed(st_nxt.wakeEn, st_nxt.wakePend) &&
			st_nxt.port_l_irq_enable && st_nxt.global_irq_enable;
	end

	// ------------------------------------------------------------
	// Notes on use
	// ------------------------------------------------------------
	// Registers answer with one wait state; clkEn must stay high
	// for the whole of a bus transfer or the answer is held off.
	// The start-up count only advances on instruction ticks, so a
	// slow oscillator stretches the delay in proportion.
	// Edge detection keeps running in halt: that is what lets a
	// port pin wake the part while the divider is stopped.
	// Pin history is also frozen by clkEn, so an edge that comes
	// and goes while frozen is never seen.
	// The reset pin acts like rstn but waits for a clock edge.

	// ------------------------------------------------------------
	// Register
	// ------------------------------------------------------------
	// Whole state is frozen while clkEn is low, except for a reset by rstn or by the reset pin
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_r          <= '0;
			st_r.mode     <= S_RUN;
			st_r.wakeEn   <= WAKE_RESET;
			st_r.wakeEdge <= WAKE_RESET;
			st_r.wakePend <= WAKE_RESET;
			st_r.oscEn    <= 1'b1;
			st_r.cpuEn    <= 1'b1;
		end else if (!resetPinN) begin
			// Reset pin returns to run, clears delay select
			st_r          <= '0;
			st_r.mode     <= S_RUN;
			st_r.oscEn    <= 1'b1;
			st_r.cpuEn    <= 1'b1;
			st_r.portLPrev <= portL;
			st_r.ckoPrev  <= clockOutPin;
		end else if (clkEn) begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign prdata       = st_r.prdata;
	assign pready       = st_r.pready;
	assign pslverr      = st_r.pslverr;
	assign instrClkEn   = st_r.tick;
	assign oscEnable    = st_r.oscEn;
	assign cpuClkEn     = st_r.cpuEn;
	assign idleTimerIrq = st_r.t0Irq;
	assign portLIrq     = st_r.lIrq;
endmodule

// file: core/halt_idle_pkg.sv
// Purpose: Constants and types for the halt/idle wakeup controller
// Assumes: APB slave with 32-bit data, one word per register
// Notes:   Offsets are byte addresses
package halt_idle_pkg;
	localparam logic [11:0] OFS_WAKE_EN    = 12'h000;
	localparam logic [11:0] OFS_WAKE_EDGE  = 12'h004;
	localparam logic [11:0] OFS_WAKE_PEND  = 12'h008;
	localparam logic [11:0] OFS_MODE_CTRL  = 12'h00c;
	localparam logic [11:0] OFS_IRQ_CTRL   = 12'h010;
	localparam logic [11:0] OFS_STATUS     = 12'h014;
	localparam logic [11:0] OFS_IDLE_TIMER = 12'h018;
	// Mode control fields
	localparam int MC_HALT   = 7;
	localparam int MC_IDLE   = 6;
	localparam int MC_CLOCK_DELAY_SELECT = 0;
	// Irq control fields
	localparam int IC_IDLE_TIMER_IRQ_ENABLE   = 0;
	localparam int IC_IDLE_TIMER_PENDING  = 1;
	localparam int IC_PORT_L_IRQ_ENABLE   = 2;
	localparam int IC_GIE    = 3;
	// Status fields
	localparam int ST_RUN    = 0;
	localparam int ST_HALT   = 1;
	localparam int ST_IDLE   = 2;
	localparam int ST_START  = 3;
	localparam int ST_REFUSE = 4;
	localparam logic [7:0]  WAKE_RESET   = 8'h00;
	localparam logic [3:0]  OSC_DIV      = 4'ha;
	localparam logic [8:0]  STARTUP_LOAD = 9'h100;
	localparam int          IDLE_BIT     = 12;
	localparam logic [31:0] SLVERR_DATA  = 32'h00000000;
	typedef enum logic [3:0] {
		S_RUN   = 4'b0001,
		S_HALT  = 4'b0010,
		S_IDLE  = 4'b0100,
		S_START = 4'b1000
	} pmode_t;
endpackage

// file: bench/halt_idle_checker.sv
// Purpose: Port-level assertions for the halt/idle wakeup controller
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to the top module at the foot of this file
`timescale 1ns/1ps
module halt_idle_checker (
	// Watched ports
	input wire logic        sys_clk,
	input wire logic        rstn,
	input wire logic        resetPinN,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        instrClkEn,
	input wire logic        oscEnable,
	input wire logic        cpuClkEn
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_access; psel && penable && !pready; endsequence
	sequence s_wake; $rose(oscEnable) && $past(resetPinN); endsequence
	property p_answer; s_access |=> pready; endproperty
	a_answer: assert property (p_answer) else $error("access not answered");
	property p_short; pready |=> !pready; endproperty
	a_short: assert property (p_short) else $error("pready longer than one cycle");
	property p_unmapped; pready && paddr > 12'h018 |-> pslverr; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
	property p_upper; pready && !pslverr |-> prdata[31:16] == 16'h0; endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	property p_divide; instrClkEn |=> !instrClkEn [*8] ##1 !instrClkEn; endproperty
	a_divide: assert property (p_divide) else $error("instruction tick too soon");
	property p_halt; !oscEnable |-> !cpuClkEn && !instrClkEn; endproperty
	a_halt: assert property (p_halt) else $error("clocks run in halt");
	property p_wake; s_wake |-> !cpuClkEn [*8]; endproperty
	a_wake: assert property (p_wake) else $error("clocks before start-up delay");
	property p_pin; !resetPinN |=> oscEnable && cpuClkEn; endproperty
	a_pin: assert property (p_pin) else $error("reset pin did not leave halt");
endmodule
bind halt_idle_wakeup_control halt_idle_checker chk_u (.sys_clk(sys_clk), .rstn(rstn),
	.resetPinN(resetPinN), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .instrClkEn(instrClkEn), .oscEnable(oscEnable),
	.cpuClkEn(cpuClkEn));

// file: bench/wake_pin_model.sv
// Purpose: Port L wake pins and clock-out pin as driven from outside
// Assumes: Push-pull drivers, so a pin holds its level between changes
// Notes:   slow delays each change by three clocks
`timescale 1ns/1ps
module wake_pin_model (
	// Control from the bench
	input  wire logic       sys_clk,
	input  wire logic [7:0] target,
	input  wire logic       slow,
	// Pins
	output logic      [7:0] portL,
	output logic            clockOutPin
);
	initial portL = 8'h00;
	// Crystal build: this pin is the oscillator output, never a wake edge
	initial clockOutPin = 1'b0;
	always @(posedge sys_clk) begin
		if (slow) repeat (3) @(posedge sys_clk);
		portL <= target;
	end
endmodule

// file: bench/tb.sv
// Purpose: Self-checking bench for the halt/idle wakeup controller
// Assumes: Crystal build, halt enabled
// Notes:   Idle timer exit is too long for the run and is left out
`timescale 1ns/1ps
module tb;
	import halt_idle_pkg::*;
	logic        sys_clk, rstn, psel, penable, pwrite, slow, resetPinN, pready, pslverr;
	logic        instrClkEn, oscEnable, cpuClkEn, idleTimerIrq, portLIrq, clockOutPin, clkEn;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, v;
	logic [7:0]  target, portL;
	logic [32:0] expQ[$];
	int          nFail, totalChecks, n;
	halt_idle_wakeup_control dut_u (.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .portL(portL), .clockOutPin(clockOutPin),
		.resetPinN(resetPinN), .instrClkEn(instrClkEn), .oscEnable(oscEnable),
		.cpuClkEn(cpuClkEn), .idleTimerIrq(idleTimerIrq), .portLIrq(portLIrq));
	wake_pin_model pin_u (.sys_clk(sys_clk), .target(target), .slow(slow), .portL(portL),
		.clockOutPin(clockOutPin));
	task endOfTest;
		$display("checks %0d mismatches %0d", totalChecks, nFail);
		if (nFail == 0 && totalChecks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [32:0] s, input logic [32:0] e, input string nm);
		totalChecks++;
		if (s !== e) begin
			nFail++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		i = 0;
		do begin @(posedge sys_clk); i++; end while (pready !== 1'b1 && i < 50);
		if (i >= 50) begin chk(33'h0, 33'h1, "pready wait"); endOfTest; end
		else begin psel <= 1'b0; penable <= 1'b0; end
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input logic err);
		expQ.push_back({err, e});
		apb(1'b0, a, 32'h0);
	endtask
	task cyc(input int k);
		repeat (k) @(posedge sys_clk);
	endtask
	// Watches every completed read against the oldest note
	always @(posedge sys_clk) if (psel && penable && pready === 1'b1 && !pwrite) begin
		if (expQ.size() == 0) chk(33'h1, 33'h0, "unexpected read");
		else chk({pslverr, prdata}, expQ.pop_front(), "read data");
	end
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		target = 0; slow = 0; resetPinN = 1; nFail = 0; totalChecks = 0; clkEn = 1;
		v = $urandom(32'ha9aa32d0);
		cyc(20);
		rstn <= 1'b1;
		rd(OFS_WAKE_EN, 0, 0); rd(OFS_WAKE_EDGE, 0, 0); rd(OFS_WAKE_PEND, 0, 0);
		rd(12'h01c, 0, 1);
		for (int i = 0; i < 4; i++) begin
			v = $urandom;
			apb(1, OFS_WAKE_EN, {24'h0, v[7:0]});
			apb(1, OFS_WAKE_EDGE, {24'h0, v[15:8]});
			rd(OFS_WAKE_EN, {24'h0, v[7:0]}, 0);
			rd(OFS_WAKE_EDGE, {24'h0, v[15:8]}, 0);
		end
		// Edges are chosen and pending cleared before any enable
		apb(1, OFS_WAKE_EN, 0); apb(1, OFS_WAKE_EDGE, 32'h0f); apb(1, OFS_WAKE_PEND, 0);
		target <= 8'hff; cyc(5); rd(OFS_WAKE_PEND, 32'hf0, 0);
		slow <= 1'b1; target <= 8'h00; cyc(10); rd(OFS_WAKE_PEND, 32'hff, 0);
		apb(1, OFS_WAKE_PEND, 0); rd(OFS_WAKE_PEND, 0, 0);
		apb(1, OFS_WAKE_EN, 1); target <= 8'h01; cyc(8); target <= 8'h00; cyc(8);
		apb(1, OFS_IRQ_CTRL, 32'hc); cyc(2); chk(portLIrq, 1, "port irq");
		apb(1, OFS_IRQ_CTRL, 32'h4); cyc(2); chk(portLIrq, 0, "port irq gated");
		apb(1, OFS_IRQ_CTRL, 32'h8); cyc(2); chk(portLIrq, 0, "port irq off");
		apb(1, OFS_MODE_CTRL, 32'h80); rd(OFS_STATUS, 32'h11, 0);
		// Edge change follows disable, select, clear, enable
		apb(1, OFS_WAKE_EN, 0); apb(1, OFS_WAKE_EDGE, 0);
		apb(1, OFS_WAKE_PEND, 0); apb(1, OFS_WAKE_EN, 1);
		apb(1, OFS_MODE_CTRL, 32'h80); cyc(5); chk(oscEnable, 0, "halt osc");
		target <= 8'h01; n = 0;
		while (cpuClkEn !== 1'b1 && n < 4000) begin @(posedge sys_clk); n++; end
		chk(n >= 2540 && n <= 2640, 1, "start-up delay");
		target <= 8'h00; cyc(8); apb(1, OFS_WAKE_PEND, 0);
		apb(1, OFS_MODE_CTRL, 32'h81); cyc(5); chk(oscEnable, 0, "halt again");
		resetPinN <= 1'b0; cyc(2); resetPinN <= 1'b1; cyc(1);
		chk(oscEnable, 1, "reset pin exit");
		rd(OFS_WAKE_EN, 0, 0);
		rd(OFS_MODE_CTRL, 0, 0);
		// Idle entry and port L wake
		apb(1, OFS_WAKE_EDGE, 0); apb(1, OFS_WAKE_PEND, 0); apb(1, OFS_WAKE_EN, 1);
		apb(1, OFS_MODE_CTRL, 32'h40); rd(OFS_STATUS, 32'h04, 0);
		chk(cpuClkEn, 0, "idle cpu clock");
		target <= 8'h01; cyc(12); rd(OFS_STATUS, 32'h01, 0);
		chk(cpuClkEn, 1, "idle exit cpu clock");
		// Clock enable low: an edge while frozen is never latched
		apb(1, OFS_WAKE_PEND, 0); n = 0;
		do begin @(posedge sys_clk); n++; end while (instrClkEn !== 1'b1 && n < 20);
		clkEn <= 1'b0; target <= 8'h00; cyc(8); target <= 8'h01; cyc(8);
		clkEn <= 1'b1; cyc(2); rd(OFS_WAKE_PEND, 0, 0);
		cyc(4);
		endOfTest;
	end
endmodule
